// ---- common/ifeb_pkg.sv ----
// package: register map, field positions and event carrier for the irq flag/enable bank
package ifeb_pkg;

  localparam int          IFEB_DW        = 8;
  localparam int          IFEB_AW        = 18;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_PIN_EN     = 16'hfff6;
  localparam logic [15:0] IDX_PORT1_FSEL = 16'hfffc;
  localparam logic [15:0] IDX_PIN_FLAGS  = 16'hfff0;
  localparam logic [15:0] IDX_MISC_FLAGS = 16'hfff1;
  localparam logic [15:0] IDX_EDGE_SEL   = 16'hfff2;
  localparam logic [15:0] IDX_MISC_CTRL  = 16'hfff3;

  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [7:0]  CNT_MAX        = 8'hff;
  localparam logic [7:0]  CNT_ZERO       = 8'h00;

  // misc flag bits
  localparam int          MF_TB1_OVF     = 0;
  localparam int          MF_DIRECT      = 1;
  // misc control bits
  localparam int          MC_DT_EN       = 0;
  localparam int          MC_TB1_IE      = 1;
  localparam int          MC_DIRECT_IE   = 2;
  // port 1 function select bit for the interrupt_request_3_input / timer v trigger pin
  localparam int          FSEL_INTERRUPT_REQUEST_3_INPUT_BIT  = 3;
  // edge select bit shared by pin 7 and the timer y clock input
  localparam int          EDGE_PIN7_BIT  = 7;

  typedef struct packed {
    logic [7:0] pin;
    logic       tb1_ovf;
    logic       direct;
  } ifeb_evt_s;

endpackage : ifeb_pkg

// ---- verilog/ifeb_top.sv ----
// irq flag/enable bank: pin edge flags, timer b1 overflow, direct transfer, wishbone slave
//////////////////////////////////////////////////////////////////////////////////////////
// Functional notes
// [R01] pin enable bit 1 passes its pin request to the core, 0 blocks; reset 0
// [R02] timer b1 overflow flag sets when counter wraps from ff to 00
// [R03] timer b1 overflow flag clears when software writes 0 while it is 1
// [R04] flags clear only by software writing 0; writing 1 never sets a flag
// [R05] each pin flag sets on its selected edge, clears by writing 0
// [R06] direct transfer flag sets on sleep with direct transfer enabled and transfer made
// [R07] edge select 1 picks rising edges on pin 7 and timer y clock input
// [R08] function select bit 1 turns the shared port pin into interrupt_request_3_input/timer v trigger input
// [R09] core request stands while any enabled flag is 1, drops when flags clear
//
// Our own choice: register access over Wishbone.
module ifeb_top
  import ifeb_pkg::*;
(
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  input  wire logic                 CYC_I,
  input  wire logic                 STB_I,
  input  wire logic                 WE_I,
  input  wire logic [IFEB_AW-1:0]   ADR_I,
  input  wire logic [3:0]           SEL_I,
  input  wire logic [31:0]          DAT_I,
  output logic      [31:0]          DAT_O,
  output logic                      ACK_O,
  input  wire logic [7:0]           EXTERNAL_INTERRUPT_PIN,
  input  wire logic                 TIMER_Y_CLOCK_INPUT,
  input  wire logic [7:0]           TIMER_B1_COUNT,
  input  wire logic                 SLEEP_EXECUTED,
  input  wire logic                 DIRECT_TRANSFER_MADE,
  input  wire logic                 PORT_PIN_IN,
  input  wire logic                 GPIO_OUT,
  input  wire logic                 GPIO_OE,
  output logic                      PORT_PIN_OUT,
  output logic                      PORT_PIN_OE,
  output logic                      GPIO_IN,
  output logic                      INTERRUPT_REQUEST_3_INPUT,
  output logic                      TIMER_V_TRIGGER_INPUT,
  output logic                      TIMER_Y_CLOCK_EDGE,
  output logic                      DIRECT_TRANSFER_ENABLE,
  output logic                      IRQ
);

  //////////////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
    edge_hit = rise ? (!prev && cur) : (prev && !cur);
  endfunction : edge_hit

  // set wins over a write-0 clear; writing 1 leaves the flag alone
  function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] set,
                                           input logic clr, input logic [7:0] wdat);
    flag_next = (clr ? (cur & wdat) : cur) | set;
  endfunction : flag_next

  logic [7:0]  pin_en_ff;
  logic [7:0]  fsel_ff;
  logic [7:0]  pin_flags_ff;
  logic [7:0]  misc_flags_ff;
  logic [7:0]  edge_sel_ff;
  logic [7:0]  misc_ctrl_ff;
  logic [7:0]  pin_prev_ff;
  logic        tmy_prev_ff;
  logic [7:0]  cnt_prev_ff;
  ifeb_evt_s   evt;
  logic        req;
  logic        wr;
  logic [15:0] idx;
  logic [7:0]  wdat;
  logic [7:0]  rdat;
  logic [7:0]  misc_set;
  logic        pend;

  //////////////////////////////////////////////////////////////////////////////////////////
  // event detection
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      evt.pin[i] = edge_hit(pin_prev_ff[i], EXTERNAL_INTERRUPT_PIN[i], edge_sel_ff[i]); // see [R05] [R07]
    end
    evt.tb1_ovf = (cnt_prev_ff == CNT_MAX) && (TIMER_B1_COUNT == CNT_ZERO); // see [R02]
    evt.direct  = SLEEP_EXECUTED && misc_ctrl_ff[MC_DT_EN] && DIRECT_TRANSFER_MADE; // see [R06]
    misc_set    = RST_BYTE;
    misc_set[MF_TB1_OVF] = evt.tb1_ovf;
    misc_set[MF_DIRECT]  = evt.direct;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      pin_prev_ff <= RST_BYTE;
      tmy_prev_ff <= 1'b0;
      cnt_prev_ff <= RST_BYTE;
    end
    else
    begin
      pin_prev_ff <= EXTERNAL_INTERRUPT_PIN;
      tmy_prev_ff <= TIMER_Y_CLOCK_INPUT;
      cnt_prev_ff <= TIMER_B1_COUNT;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
      TIMER_Y_CLOCK_EDGE <= 1'b0;
    else
      TIMER_Y_CLOCK_EDGE <= edge_hit(tmy_prev_ff, TIMER_Y_CLOCK_INPUT,
                                     edge_sel_ff[EDGE_PIN7_BIT]); // see [R07]
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // wishbone slave
  assign req  = CYC_I && STB_I && !ACK_O;
  assign idx  = ADR_I[IFEB_AW-1:2];
  assign wr   = req && WE_I && SEL_I[0];
  assign wdat = DAT_I[IFEB_DW-1:0];

  always_comb
  begin
    unique case (idx)
      IDX_PIN_EN:     rdat = pin_en_ff;
      IDX_PORT1_FSEL: rdat = fsel_ff;
      IDX_PIN_FLAGS:  rdat = pin_flags_ff;
      IDX_MISC_FLAGS: rdat = misc_flags_ff;
      IDX_EDGE_SEL:   rdat = edge_sel_ff;
      IDX_MISC_CTRL:  rdat = misc_ctrl_ff;
      default:        rdat = RST_BYTE;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      ACK_O <= 1'b0;
      DAT_O <= {24'h00_0000, RST_BYTE};
    end
    else
    begin
      ACK_O <= req;
      DAT_O <= {24'h00_0000, req ? rdat : RST_BYTE};
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      pin_en_ff    <= RST_BYTE; // see [R01]
      fsel_ff      <= RST_BYTE;
      edge_sel_ff  <= RST_BYTE;
      misc_ctrl_ff <= RST_BYTE;
    end
    else if (wr)
    begin
      if (idx == IDX_PIN_EN)     pin_en_ff    <= wdat;
      if (idx == IDX_PORT1_FSEL) fsel_ff      <= wdat;
      if (idx == IDX_EDGE_SEL)   edge_sel_ff  <= wdat;
      if (idx == IDX_MISC_CTRL)  misc_ctrl_ff <= wdat;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      pin_flags_ff  <= RST_BYTE;
      misc_flags_ff <= RST_BYTE;
    end
    else
    begin
      pin_flags_ff  <= flag_next(pin_flags_ff, evt.pin,
                                 wr && (idx == IDX_PIN_FLAGS), wdat); // see [R04] [R05]
      misc_flags_ff <= flag_next(misc_flags_ff, misc_set,
                                 wr && (idx == IDX_MISC_FLAGS), wdat); // see [R03] [R04]
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // request to the core and pin function select
  assign pend = |(pin_flags_ff & pin_en_ff)
              || (misc_flags_ff[MF_TB1_OVF] && misc_ctrl_ff[MC_TB1_IE])
              || (misc_flags_ff[MF_DIRECT] && misc_ctrl_ff[MC_DIRECT_IE]); // see [R01] [R09]

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      IRQ                    <= 1'b0;
      DIRECT_TRANSFER_ENABLE <= 1'b0;
    end
    else
    begin
      IRQ                    <= pend; // see [R09]
      DIRECT_TRANSFER_ENABLE <= misc_ctrl_ff[MC_DT_EN];
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      PORT_PIN_OUT              <= 1'b0;
      PORT_PIN_OE               <= 1'b0;
      GPIO_IN                   <= 1'b0;
      INTERRUPT_REQUEST_3_INPUT <= 1'b0;
      TIMER_V_TRIGGER_INPUT     <= 1'b0;
    end
    else if (fsel_ff[FSEL_INTERRUPT_REQUEST_3_INPUT_BIT])
    begin
      PORT_PIN_OUT              <= 1'b0; // see [R08]
      PORT_PIN_OE               <= 1'b0;
      GPIO_IN                   <= 1'b0;
      INTERRUPT_REQUEST_3_INPUT <= PORT_PIN_IN;
      TIMER_V_TRIGGER_INPUT     <= PORT_PIN_IN;
    end
    else
    begin
      PORT_PIN_OUT              <= GPIO_OUT;
      PORT_PIN_OE               <= GPIO_OE;
      GPIO_IN                   <= PORT_PIN_IN;
      INTERRUPT_REQUEST_3_INPUT <= 1'b0;
      TIMER_V_TRIGGER_INPUT     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // checks
  pin_block_a: assert property (@(posedge CLOCK) disable iff (RST) // see [R01]
    (pin_en_ff == RST_BYTE) && (misc_ctrl_ff[MC_TB1_IE] == 1'b0)
      && (misc_ctrl_ff[MC_DIRECT_IE] == 1'b0) |=> !IRQ)
    else $error("irq raised with all enables off");

  tb1_wrap_a: assert property (@(posedge CLOCK) disable iff (RST) // see [R02]
    (cnt_prev_ff == CNT_MAX) && (TIMER_B1_COUNT == CNT_ZERO) |=> misc_flags_ff[MF_TB1_OVF])
    else $error("timer b1 wrap did not set flag");

  tb1_clear_a: assert property (@(posedge CLOCK) disable iff (RST) // see [R03]
    wr && (idx == IDX_MISC_FLAGS) && !wdat[MF_TB1_OVF] && !evt.tb1_ovf
      |=> !misc_flags_ff[MF_TB1_OVF])
    else $error("timer b1 flag not cleared by write 0");

  no_set_a: assert property (@(posedge CLOCK) disable iff (RST) // see [R04]
    (evt.pin == RST_BYTE) |=> ((pin_flags_ff & ~$past(pin_flags_ff)) == RST_BYTE))
    else $error("pin flag set without edge");

  pin_flag_a: assert property (@(posedge CLOCK) disable iff (RST) // see [R05]
    ##1 ((pin_flags_ff & $past(evt.pin)) == $past(evt.pin)))
    else $error("pin edge did not set flag");

  direct_set_a: assert property (@(posedge CLOCK) disable iff (RST) // see [R06]
    SLEEP_EXECUTED && misc_ctrl_ff[MC_DT_EN] && DIRECT_TRANSFER_MADE
      |=> misc_flags_ff[MF_DIRECT])
    else $error("direct transfer flag not set");

  rise_sel_a: assert property (@(posedge CLOCK) disable iff (RST) // see [R07]
    edge_sel_ff[EDGE_PIN7_BIT] && pin_prev_ff[7] && !EXTERNAL_INTERRUPT_PIN[7]
      && !pin_flags_ff[7] && !wr |=> !pin_flags_ff[7])
    else $error("falling edge taken in rising mode");

  pin_func_a: assert property (@(posedge CLOCK) disable iff (RST) // see [R08]
    fsel_ff[FSEL_INTERRUPT_REQUEST_3_INPUT_BIT] |=> !PORT_PIN_OE && (INTERRUPT_REQUEST_3_INPUT == $past(PORT_PIN_IN)))
    else $error("shared pin not in trigger mode");

  irq_drop_a: assert property (@(posedge CLOCK) disable iff (RST) // see [R09]
    (pin_flags_ff == RST_BYTE) && (misc_flags_ff == RST_BYTE) |=> !IRQ)
    else $error("irq stands with no flag set");

  ack_pulse_a: assert property (@(posedge CLOCK) disable iff (RST)
    ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");

endmodule : ifeb_top

// ---- verification/ifeb_far_model.sv ----
// far-side model: external pins, timer b1 counter and shared port pin
module ifeb_far_model
  import ifeb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [7:0] pin_req,
  input  wire logic       port_req,
  input  wire logic       pin_oe,
  input  wire logic       pin_out,
  output logic      [7:0] pins,
  output logic      [7:0] count,
  output logic            port_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // free counter, wraps ff to 00
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_ff <= CNT_ZERO;
    else if (run)
      cnt_ff <= cnt_ff + 8'h01;
  end
  assign count = cnt_ff;
  assign pins = pin_req;
  // resolved shared pin: block drive wins over far side
  assign port_pin = pin_oe ? pin_out : port_req;
endmodule : ifeb_far_model

// ---- verification/ifeb_top_tb.sv ----
// self-checking bench for the irq flag/enable bank
module ifeb_top_tb
  import ifeb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [15:0] idx; logic [7:0] wd; logic [7:0] rd;} ifeb_row_s;
  logic        clock;
  logic        rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0;
  logic        slp = 1'b0, made = 1'b0, tyc = 1'b0, port_req = 1'b0;
  logic        gpo = 1'b0, gpoe = 1'b0;
  logic [3:0]  sel = 4'hf;
  logic [17:0] adr = '0;
  logic [31:0] dat_i = '0, dat_o;
  logic [7:0]  pin_req = 8'hff, pins, count, q;
  logic        ack, irq, gpio_in, req3_in, vtrig, ty_edge, dt_en, p_out, p_oe, port_pin;
  int          error_cnt = 0, checks = 0, ty_cnt = 0;
  ifeb_row_s   rows [7] = '{'{IDX_PIN_EN, 8'ha5, 8'ha5}, '{IDX_PORT1_FSEL, 8'hc4, 8'hc4},
    '{IDX_EDGE_SEL, 8'h5a, 8'h5a}, '{IDX_MISC_CTRL, 8'h06, 8'h06},
    '{IDX_PIN_FLAGS, 8'hff, 8'h00}, '{IDX_MISC_FLAGS, 8'hff, 8'h00}, '{16'h0010, 8'hff, 8'h00}};
  ////////////////////////////////////////////////////////////////////////////////
  ifeb_top u_ifeb_top (.CLOCK(clock), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack),
    .EXTERNAL_INTERRUPT_PIN(pins), .TIMER_Y_CLOCK_INPUT(tyc), .TIMER_B1_COUNT(count),
    .SLEEP_EXECUTED(slp), .DIRECT_TRANSFER_MADE(made), .PORT_PIN_IN(port_pin),
    .GPIO_OUT(gpo), .GPIO_OE(gpoe), .PORT_PIN_OUT(p_out), .PORT_PIN_OE(p_oe),
    .GPIO_IN(gpio_in), .INTERRUPT_REQUEST_3_INPUT(req3_in), .TIMER_V_TRIGGER_INPUT(vtrig),
    .TIMER_Y_CLOCK_EDGE(ty_edge), .DIRECT_TRANSFER_ENABLE(dt_en), .IRQ(irq));
  ifeb_far_model u_ifeb_far_model (.clk(clock), .rst(rst), .run(run), .pin_req(pin_req),
    .port_req(port_req), .pin_oe(p_oe), .pin_out(p_out), .pins(pins), .count(count),
    .port_pin(port_pin));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock)
    if (ty_edge === 1'b1) ty_cnt <= ty_cnt + 1;
  initial
  begin
    repeat (4000) @(posedge clock);
    error_cnt++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask : w
  task automatic bus(input logic wr_en, input logic [15:0] i, input logic [7:0] d,
                     input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr_en;
    sel <= s;
    adr <= {i, 2'b00};
    dat_i <= {24'h00_0000, d};
    do
    begin
      @(posedge clock);
    end
    while (ack !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    bus(1'b1, i, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [15:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00, 4'hf);
    chk(q, e);
  endtask : rd
  task automatic conclude();
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    w(8);
    rst <= 1'b0;
    w(1);
    rd(IDX_PIN_EN, RST_BYTE);
    rd(IDX_PIN_FLAGS, RST_BYTE);
    foreach (rows[k])
    begin
      wr(rows[k].idx, rows[k].wd);
      rd(rows[k].idx, rows[k].rd);
    end
    wr(IDX_PORT1_FSEL, 8'h00);
    wr(IDX_EDGE_SEL, 8'h00);
    wr(IDX_MISC_CTRL, 8'h00);
    wr(IDX_PIN_EN, 8'hff);
    pin_req <= 8'hfb;
    w(3);
    rd(IDX_PIN_FLAGS, 8'h04);
    chk(irq, 32'h1);
    wr(IDX_PIN_FLAGS, 8'hfb);
    w(2);
    rd(IDX_PIN_FLAGS, 8'h00);
    chk(irq, 32'h0);
    wr(IDX_PIN_EN, 8'hfb);
    pin_req <= 8'hff;
    w(3);
    pin_req <= 8'hfb;
    w(3);
    rd(IDX_PIN_FLAGS, 8'h04);
    chk(irq, 32'h0);
    wr(IDX_PIN_FLAGS, 8'h00);
    wr(IDX_EDGE_SEL, 8'h80);
    pin_req <= 8'h7b;
    w(3);
    rd(IDX_PIN_FLAGS, 8'h00);
    pin_req <= 8'hfb;
    tyc <= 1'b1;
    w(3);
    tyc <= 1'b0;
    w(3);
    rd(IDX_PIN_FLAGS, 8'h80);
    chk(ty_cnt, 32'h1);
    wr(IDX_PIN_FLAGS, 8'h00);
    run <= 1'b1;
    w(260);
    run <= 1'b0;
    rd(IDX_MISC_FLAGS, 8'h01);
    wr(IDX_MISC_FLAGS, 8'h00);
    rd(IDX_MISC_FLAGS, 8'h00);
    wr(IDX_MISC_CTRL, 8'h05);
    chk(dt_en, 32'h1);
    slp <= 1'b1;
    w(1);
    slp <= 1'b0;
    w(2);
    rd(IDX_MISC_FLAGS, 8'h00);
    slp <= 1'b1;
    made <= 1'b1;
    w(1);
    slp <= 1'b0;
    made <= 1'b0;
    w(3);
    rd(IDX_MISC_FLAGS, 8'h02);
    chk(irq, 32'h1);
    wr(IDX_MISC_FLAGS, 8'h00);
    w(2);
    chk(irq, 32'h0);
    port_req <= 1'b1;
    w(3);
    chk({gpio_in, req3_in, vtrig}, 32'h4);
    gpoe <= 1'b1;
    w(3);
    chk({p_out, p_oe, gpio_in}, 32'h2);
    wr(IDX_PORT1_FSEL, 8'h08);
    w(2);
    chk({gpio_in, req3_in, vtrig, p_oe}, 32'h6);
    // pin edge in the very cycle of a write-0 clear: the set must win
    pin_req <= 8'hf9;
    wr(IDX_PIN_FLAGS, 8'h00);
    rd(IDX_PIN_FLAGS, 8'h02);
    chk(irq, 32'h1);
    wr(IDX_EDGE_SEL, 8'h02);
    wr(IDX_PIN_FLAGS, 8'h00);
    rd(IDX_PIN_FLAGS, 8'h00);
    pin_req <= 8'hfb;
    w(3);
    rd(IDX_PIN_FLAGS, 8'h02);
    // write with the low byte lane off must be dropped
    bus(1'b1, IDX_PIN_EN, 8'h00, 4'he);
    rd(IDX_PIN_EN, 8'hfb);
    // reset in mid-run with a request standing
    rst <= 1'b1;
    w(2);
    rst <= 1'b0;
    w(1);
    chk({irq, req3_in, vtrig}, 32'h0);
    rd(IDX_PIN_EN, RST_BYTE);
    rd(IDX_PIN_FLAGS, RST_BYTE);
    conclude();
  end
endmodule : ifeb_top_tb
